// ===== rtl/bcx_exec.sv
// branch group two and control instruction execution sequencer
`timescale 1ns/100ps
`default_nettype none
`include "bcx_regs.svh"

module bcx_exec #(
  parameter int COST_W = 4
) (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst_n,
  // instruction issue
  input  wire logic                i_start,
  input  wire bcx_pkg::bcx_op_t    i_op,
  input  wire logic                i_word,
  input  wire logic [15:0]         i_opnd,
  input  wire logic [15:0]         i_imm,
  input  wire logic [COST_W-1:0]   i_ea_cost,
  input  wire logic [7:0]          i_rlst,
  input  wire bcx_pkg::bcx_bank_t  i_bank,
  input  wire logic [7:0]          i_bank_val,
  // memory bus
  input  wire logic [15:0]         i_mem_rdata,
  output logic                     o_mem_req,
  output logic                     o_mem_we,
  output logic [15:0]              o_mem_wdata,
  output logic                     o_reg_xfer,
  // completion and results
  output logic                     o_busy,
  output logic                     o_done,
  output logic                     o_taken,
  output logic [15:0]              o_result,
  output logic                     o_wb,
  output logic                     o_acc_load,
  output logic [15:0]              o_pc,
  output logic                     o_pc_load,
  output logic [7:0]               o_prog_bank,
  output logic [15:0]              o_fp,
  output logic                     o_fp_load,
  // core state
  output logic [6:0]               o_cond_code,
  output logic [7:0]               o_reg_bank_ptr,
  output logic [2:0]               o_int_level_mask,
  output logic                     o_space_ovr,
  output logic [1:0]               o_space,
  output logic                     o_flag_hold,
  output logic                     o_shared_bank,
  // register port
  input  wire logic [7:0]          i_reg_addr,
  input  wire logic [15:0]         i_reg_wdata,
  input  wire logic                i_reg_wr,
  input  wire logic                i_reg_rd,
  output logic [15:0]              o_reg_rdata
);
  import bcx_pkg::*;

  // counts are held in six bits, so the cost field must stay narrow
  if (COST_W < 1 || COST_W > 5) begin : g_chk
    $error("COST_W must lie between 1 and 5");
  end

  bcx_op_t     op_q;
  logic        word_q;
  logic        mem_q;
  logic [15:0] imm_q;
  logic [5:0]  cnt_q;
  logic [5:0]  tot_q;
  logic [5:0]  last_q;
  logic [3:0]  acc_q;
  logic [2:0]  rd_idx_q;
  logic [15:0] rd0_q;
  logic [15:0] rd1_q;
  logic        taken_q;
  logic [15:0] res_q;
  logic [3:0]  nzvc_q;
  logic        list_q;
  logic        start;
  logic        fin;
  logic        rd_fire;
  logic        first_mem_rd;
  bcx_op_t     cur_op;
  logic        cur_word;
  logic        cur_dec;
  logic [15:0] src;
  logic [15:0] sub_b;
  logic [16:0] d16;
  logic [8:0]  d8;
  logic [3:0]  nzvc_c;
  logic [15:0] res_c;
  logic        taken_c;
  logic [3:0]  n_cnt;
  logic [2:0]  lo;
  logic [2:0]  hi;
  logic [5:0]  cyc_c;
  logic [3:0]  acc_c;
  logic        we_c;
  logic [5:0]  cost;
  logic        is_pfx;
  logic        is_br;

  assign start        = i_start & ~o_busy;
  assign fin          = o_busy & (cnt_q == 6'h01);
  assign rd_fire      = o_busy & o_mem_req & ~o_mem_we;
  assign first_mem_rd = rd_fire & (rd_idx_q == 3'h0) & mem_q;
  assign cost         = 6'(i_ea_cost);
  assign is_pfx       = (op_q >= OP_PFX_ADD) && (op_q <= OP_PFX_SHARED);
  assign is_br        = (op_q >= OP_CMP_ACC) && (op_q <= OP_DEC_MEM);

  // operand source: pin value at issue, read data for memory forms
  always_comb begin
    cur_op   = o_busy ? op_q : i_op;
    cur_word = o_busy ? word_q : i_word;
    src      = o_busy ? i_mem_rdata : i_opnd;
    cur_dec  = (cur_op == OP_DEC_REG) || (cur_op == OP_DEC_MEM);
    sub_b    = cur_dec ? 16'h0001 : (o_busy ? imm_q : i_imm);
    d16      = {1'b0, src} - {1'b0, sub_b};
    d8       = {1'b0, src[7:0]} - {1'b0, sub_b[7:0]};
    if (cur_word) begin
      res_c  = d16[15:0];
      nzvc_c = {d16[15], d16[15:0] == 16'h0000,
                (src[15] ^ sub_b[15]) & (src[15] ^ d16[15]), d16[16]};
    end else begin
      res_c  = {8'h00, d8[7:0]};
      nzvc_c = {d8[7], d8[7:0] == 8'h00,
                (src[7] ^ sub_b[7]) & (src[7] ^ d8[7]), d8[8]};
    end
    taken_c  = ~nzvc_c[2]; // unequal and nonzero both mean nonzero difference
  end

  // register list size and first and last index
  always_comb begin
    n_cnt = 4'h0;
    lo    = 3'h0;
    hi    = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (i_rlst[k]) begin
        n_cnt = n_cnt + 4'h1;
        lo    = 3'(k);
      end
    end
    for (int k = 0; k < 8; k++) begin
      if (i_rlst[k]) begin
        hi = 3'(k);
      end
    end
  end

  // cycles, word accesses and direction per instruction
  always_comb begin
    cyc_c = `BCX_CYC_ONE;
    acc_c = 4'h0;
    we_c  = 1'b0;
    case (i_op)
      OP_CMP_ACC: cyc_c = `BCX_CYC_CMP_ACC + {5'h00, taken_c};
      OP_CMP_REG: begin
        cyc_c = (i_word ? `BCX_CYC_CMP_WREG : `BCX_CYC_CMP_BREG)
              + {5'h00, taken_c};
      end
      OP_CMP_MEM: begin
        cyc_c = `BCX_CYC_CMP_MEM + cost;
        acc_c = 4'h1;
      end
      OP_DEC_REG: cyc_c = `BCX_CYC_DEC_REG + {5'h00, taken_c};
      OP_DEC_MEM: begin
        cyc_c = `BCX_CYC_DEC_MEM + cost;
        acc_c = 4'h2;
      end
      OP_INT_VEC, OP_INT_ONE: begin
        cyc_c = `BCX_CYC_INT_VEC;
        acc_c = `BCX_ACC_INT_LONG;
        we_c  = 1'b1;
      end
      OP_INT_A16, OP_INT_FAR: begin
        cyc_c = (i_op == OP_INT_A16) ? `BCX_CYC_INT_A16 : `BCX_CYC_INT_FAR;
        acc_c = `BCX_ACC_SIX;
        we_c  = 1'b1;
      end
      OP_INT_RETURN: begin
        cyc_c = `BCX_CYC_INT_RET;
        acc_c = `BCX_ACC_SIX;
      end
      OP_LINK: begin
        cyc_c = `BCX_CYC_LINK;
        acc_c = 4'h1;
        we_c  = 1'b1;
      end
      OP_FRAME_TEARDOWN: begin
        cyc_c = `BCX_CYC_FRAME_TEARDOWN;
        acc_c = 4'h1;
      end
      OP_RET: begin
        cyc_c = `BCX_CYC_RET;
        acc_c = 4'h1;
      end
      OP_FAR_RETURN: begin
        cyc_c = `BCX_CYC_FAR_RET;
        acc_c = 4'h2;
      end
      OP_PUSH_LIST: begin
        cyc_c = (n_cnt == 4'h0) ? `BCX_CYC_PUSH_NONE
              : `BCX_CYC_PUSH_BASE + {2'h0, n_cnt} - {3'h0, lo} * 6'h03;
        acc_c = n_cnt;
        we_c  = 1'b1;
      end
      OP_POP_LIST: begin
        cyc_c = (n_cnt == 4'h0) ? `BCX_CYC_POP_NONE
              : `BCX_CYC_POP_BASE + {2'h0, n_cnt} * 6'h03 + {2'h0, hi, 1'b0};
        acc_c = n_cnt;
      end
      OP_CTX_SWITCH: begin
        cyc_c = `BCX_CYC_CTX;
        acc_c = `BCX_ACC_SIX;
      end
      OP_AND_COND, OP_OR_COND: cyc_c = `BCX_CYC_COND_OP;
      OP_MOV_RBP, OP_MOV_ILM:  cyc_c = `BCX_CYC_MOV_IMM;
      OP_RD_BANK: begin
        cyc_c = (i_bank >= BANK_DATA) ? `BCX_CYC_BANK_SLOW
              : `BCX_CYC_BANK_FAST;
      end
      default: cyc_c = `BCX_CYC_ONE;
    endcase
  end

  // issue, cycle count and completion; a memory branch adds its cycle late
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      cnt_q  <= 6'h00;
      tot_q  <= 6'h00;
      last_q <= 6'h00;
      op_q   <= OP_NOP;
      word_q <= 1'b0;
      mem_q  <= 1'b0;
      imm_q  <= 16'h0000;
      list_q <= 1'b0;
    end else begin
      o_done <= fin;
      if (start) begin
        o_busy <= 1'b1;
        cnt_q  <= cyc_c;
        tot_q  <= 6'h01;
        op_q   <= i_op;
        word_q <= i_word;
        mem_q  <= (i_op == OP_CMP_MEM) || (i_op == OP_DEC_MEM);
        imm_q  <= i_imm;
        list_q <= (i_op == OP_PUSH_LIST) || (i_op == OP_POP_LIST);
      end else if (o_busy) begin
        cnt_q <= cnt_q - 6'h01 + {5'h00, first_mem_rd & taken_c};
        tot_q <= tot_q + 6'h01;
        if (fin) begin
          o_busy <= 1'b0;
          last_q <= tot_q;
        end
      end
    end
  end

  // word access sequencer, one access per busy cycle from the first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_q       <= 4'h0;
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_wdata <= 16'h0000;
      o_reg_xfer  <= 1'b0;
      rd_idx_q    <= 3'h0;
      rd0_q       <= 16'h0000;
      rd1_q       <= 16'h0000;
    end else if (start) begin
      acc_q       <= acc_c;
      o_mem_req   <= acc_c != 4'h0;
      o_mem_we    <= we_c;
      o_mem_wdata <= (i_op == OP_LINK || i_op == OP_PUSH_LIST) ? i_opnd
                   : {9'h000, o_cond_code};
      o_reg_xfer  <= (acc_c != 4'h0) &&
                     ((i_op == OP_PUSH_LIST) || (i_op == OP_POP_LIST));
      rd_idx_q    <= 3'h0;
    end else if (o_busy && o_mem_req) begin
      acc_q      <= acc_q - 4'h1;
      o_mem_req  <= acc_q > 4'h1;
      o_reg_xfer <= list_q && (acc_q > 4'h1);
      if (rd_fire) begin
        rd_idx_q <= rd_idx_q + 3'h1;
        if (rd_idx_q == 3'h0) begin
          rd0_q <= i_mem_rdata;
        end
        if (rd_idx_q == 3'h1) begin
          rd1_q <= i_mem_rdata;
        end
        // read-modify-write: the decremented value goes back out
        if (first_mem_rd && op_q == OP_DEC_MEM) begin
          o_mem_we    <= 1'b1;
          o_mem_wdata <= res_c;
        end
      end
    end
  end

  // branch outcome and arithmetic, caught at issue or at the operand read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      taken_q <= 1'b0;
      res_q   <= 16'h0000;
      nzvc_q  <= 4'h0;
    end else if (start) begin
      taken_q <= taken_c;
      res_q   <= (i_op == OP_RD_BANK) ? {8'h00, i_bank_val} : res_c;
      nzvc_q  <= nzvc_c;
    end else if (first_mem_rd) begin
      taken_q <= taken_c;
      res_q   <= res_c;
      nzvc_q  <= nzvc_c;
    end
  end

  // results handed back to the core at completion
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_taken     <= 1'b0;
      o_result    <= 16'h0000;
      o_wb        <= 1'b0;
      o_acc_load  <= 1'b0;
      o_pc        <= 16'h0000;
      o_pc_load   <= 1'b0;
      o_prog_bank <= 8'h00;
      o_fp        <= 16'h0000;
      o_fp_load   <= 1'b0;
    end else begin
      o_taken    <= fin & is_br & taken_q;
      o_wb       <= fin & (op_q == OP_DEC_REG);
      o_acc_load <= fin & (op_q == OP_RD_BANK);
      o_pc_load  <= fin & ((op_q == OP_RET) || (op_q == OP_FAR_RETURN) ||
                           (op_q == OP_INT_RETURN) || (op_q == OP_CTX_SWITCH));
      o_fp_load  <= fin & ((op_q == OP_LINK) || (op_q == OP_FRAME_TEARDOWN));
      if (fin) begin
        o_result <= res_q;
        o_pc     <= (op_q == OP_RET || op_q == OP_FAR_RETURN) ? rd0_q : rd1_q;
        o_fp     <= (op_q == OP_LINK) ? imm_q : rd0_q;
        if (op_q == OP_FAR_RETURN) begin
          o_prog_bank <= rd1_q[7:0];
        end
      end
    end
  end

  // condition codes; hardware completion wins over a software write except under the no-flag prefix
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cond_code <= `BCX_RST_COND;
    end else if (fin && !o_flag_hold) begin
      unique case (op_q)
        OP_CMP_ACC, OP_CMP_REG, OP_CMP_MEM: begin
          o_cond_code[`BCX_F_Z] <= nzvc_q[2];
          o_cond_code[`BCX_F_V] <= nzvc_q[1];
          o_cond_code[`BCX_F_C] <= nzvc_q[0];
        end
        OP_DEC_REG, OP_DEC_MEM: begin
          o_cond_code[`BCX_F_N] <= nzvc_q[3];
          o_cond_code[`BCX_F_Z] <= nzvc_q[2];
          o_cond_code[`BCX_F_V] <= nzvc_q[1];
        end
        OP_INT_VEC, OP_INT_A16, OP_INT_FAR, OP_INT_ONE: begin
          o_cond_code[`BCX_F_I] <= 1'b0;
          o_cond_code[`BCX_F_S] <= 1'b1;
        end
        OP_INT_RETURN, OP_CTX_SWITCH: o_cond_code <= rd0_q[6:0];
        OP_AND_COND: o_cond_code <= o_cond_code & imm_q[6:0];
        OP_OR_COND:  o_cond_code <= o_cond_code | imm_q[6:0];
        default:     o_cond_code <= o_cond_code;
      endcase
    end else if (i_reg_wr && i_reg_addr == `BCX_OFS_COND) begin
      o_cond_code <= i_reg_wdata[6:0];
    end
  end

  // bank pointer and level mask, loaded by immediates or software
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_bank_ptr   <= `BCX_RST_RBP;
      o_int_level_mask <= `BCX_RST_ILM;
    end else begin
      if (fin && op_q == OP_MOV_RBP) begin
        o_reg_bank_ptr <= imm_q[7:0];
      end else if (i_reg_wr && i_reg_addr == `BCX_OFS_RBP) begin
        o_reg_bank_ptr <= i_reg_wdata[7:0];
      end
      if (fin && op_q == OP_MOV_ILM) begin
        o_int_level_mask <= imm_q[2:0];
      end else if (i_reg_wr && i_reg_addr == `BCX_OFS_ILM) begin
        o_int_level_mask <= i_reg_wdata[2:0];
      end
    end
  end

  // prefixes stack up and last until the next real instruction completes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_space_ovr   <= 1'b0;
      o_space       <= 2'h0;
      o_flag_hold   <= 1'b0;
      o_shared_bank <= 1'b0;
    end else if (fin && is_pfx) begin
      if (op_q <= OP_PFX_STACK) begin
        o_space_ovr <= 1'b1;
        o_space     <= 2'(op_q - OP_PFX_ADD);
      end
      if (op_q == OP_PFX_NOFLAG) begin
        o_flag_hold <= 1'b1;
      end
      if (op_q == OP_PFX_SHARED) begin
        o_shared_bank <= 1'b1;
      end
    end else if (fin) begin
      o_space_ovr   <= 1'b0;
      o_space       <= 2'h0;
      o_flag_hold   <= 1'b0;
      o_shared_bank <= 1'b0;
    end
  end

  // register read port, data in the cycle after the strobe only
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 16'h0000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `BCX_OFS_COND: o_reg_rdata <= {9'h000, o_cond_code};
        `BCX_OFS_RBP:  o_reg_rdata <= {8'h00, o_reg_bank_ptr};
        `BCX_OFS_ILM:  o_reg_rdata <= {13'h0000, o_int_level_mask};
        `BCX_OFS_STAT: o_reg_rdata <= {o_busy, taken_q, 8'h00, last_q};
        `BCX_OFS_PFX:  o_reg_rdata <= {11'h000, o_shared_bank, o_flag_hold,
                                       o_space_ovr, o_space};
        default:       o_reg_rdata <= 16'h0000;
      endcase
    end else begin
      o_reg_rdata <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/bcx_regs.svh
// register offsets, field positions, reset values and cycle counts of the exec block
// Notes on behaviour
// - accumulator compare-branch: 5 taken, 4 not
// - byte register compare-branch: 13/12, sets Z V C
// - word register compare-branch: 8 taken, 7 not
// - memory compare-branch: 7+cost taken, 6+cost not
// - decrement, write back, branch when nonzero
// - register decrement-branch: 7 taken, 6 not
// - memory decrement-branch: 8+cost/7+cost, read-modify-write
// - soft interrupts clear I, set S; 20/16/17
// - interrupt return: 15 cycles, six reads, flags
// - frame setup: push old pointer, 6 cycles
// - frame teardown: restore pointer in 5 cycles
// - near return pops one word, 4 cycles
// - far return pops pc and bank, 6
// - empty list: push 8 cycles, pop 7
// - one access and transfer per listed register
// - context switch: 14 cycles, six accesses, flags
// - bank read: 1 state, data/direct page 2
// - bank prefixes: 1 cycle, redirect next access
// - no-flag prefix: 1 cycle, next keeps flags
// - shared bank prefix: 1 cycle, next shared
`ifndef BCX_REGS_SVH
`define BCX_REGS_SVH

// register port offsets
`define BCX_OFS_COND      8'h00
`define BCX_OFS_RBP       8'h04
`define BCX_OFS_ILM       8'h08
`define BCX_OFS_STAT      8'h0c
`define BCX_OFS_PFX       8'h10

// flag positions in the condition code register
`define BCX_F_I           6
`define BCX_F_S           5
`define BCX_F_N           3
`define BCX_F_Z           2
`define BCX_F_V           1
`define BCX_F_C           0

// reset values
`define BCX_RST_COND      7'h00
`define BCX_RST_RBP       8'h00
`define BCX_RST_ILM       3'h0

// cycle counts, not-taken figure where a branch adds one
`define BCX_CYC_CMP_ACC   6'h04
`define BCX_CYC_CMP_BREG  6'h0c
`define BCX_CYC_CMP_WREG  6'h07
`define BCX_CYC_CMP_MEM   6'h06
`define BCX_CYC_DEC_REG   6'h06
`define BCX_CYC_DEC_MEM   6'h07
`define BCX_CYC_INT_VEC   6'h14
`define BCX_CYC_INT_A16   6'h10
`define BCX_CYC_INT_FAR   6'h11
`define BCX_CYC_INT_RET   6'h0f
`define BCX_CYC_LINK      6'h06
`define BCX_CYC_FRAME_TEARDOWN    6'h05
`define BCX_CYC_RET       6'h04
`define BCX_CYC_FAR_RET   6'h06
`define BCX_CYC_PUSH_NONE 6'h08
`define BCX_CYC_POP_NONE  6'h07
`define BCX_CYC_PUSH_BASE 6'h1d
`define BCX_CYC_POP_BASE  6'h07
`define BCX_CYC_CTX       6'h0e
`define BCX_CYC_COND_OP   6'h03
`define BCX_CYC_MOV_IMM   6'h02
`define BCX_CYC_BANK_FAST 6'h01
`define BCX_CYC_BANK_SLOW 6'h02
`define BCX_CYC_ONE       6'h01

// word access counts
`define BCX_ACC_INT_LONG  4'h8
`define BCX_ACC_SIX       4'h6

`endif

// ===== rtl/bcx_pkg.sv
// types shared by the branch and control exec block
package bcx_pkg;

  // instruction classes handed in by the decoder
  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_CMP_ACC    = 5'h01,
    OP_CMP_REG    = 5'h02,
    OP_CMP_MEM    = 5'h03,
    OP_DEC_REG    = 5'h04,
    OP_DEC_MEM    = 5'h05,
    OP_INT_VEC    = 5'h06,
    OP_INT_A16    = 5'h07,
    OP_INT_FAR    = 5'h08,
    OP_INT_ONE    = 5'h09,
    OP_INT_RETURN = 5'h0a,
    OP_LINK       = 5'h0b,
    OP_FRAME_TEARDOWN     = 5'h0c,
    OP_RET        = 5'h0d,
    OP_FAR_RETURN = 5'h0e,
    OP_PUSH_LIST  = 5'h0f,
    OP_POP_LIST   = 5'h10,
    OP_CTX_SWITCH = 5'h11,
    OP_AND_COND   = 5'h12,
    OP_OR_COND    = 5'h13,
    OP_MOV_RBP    = 5'h14,
    OP_MOV_ILM    = 5'h15,
    OP_RD_BANK    = 5'h16,
    OP_PFX_ADD    = 5'h17,
    OP_PFX_DATA   = 5'h18,
    OP_PFX_PROG   = 5'h19,
    OP_PFX_STACK  = 5'h1a,
    OP_PFX_NOFLAG = 5'h1b,
    OP_PFX_SHARED = 5'h1c
  } bcx_op_t;

  // bank register picked by the bank read
  typedef enum logic [2:0] {
    BANK_PROG     = 3'h0,
    BANK_ADD      = 3'h1,
    BANK_SYS_STK  = 3'h2,
    BANK_USER_STK = 3'h3,
    BANK_STACK    = 3'h4,
    BANK_DATA     = 3'h5,
    BANK_DPAGE    = 3'h6
  } bcx_bank_t;

endpackage

// ===== bench/bcx_mem_model.sv
// zero-wait memory model for the exec block
`timescale 1ns/100ps
`default_nettype none
module bcx_mem_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // word bus
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_base,
  output logic      [15:0] o_rdata,
  // access log
  output var int           o_nrd,
  output var int           o_nwr,
  output logic      [15:0] o_lastw
);
  // same-cycle answer; idle bus shows the inverse
  assign o_rdata = (i_req && !i_we) ? i_base : ~i_base;
  // one word per request cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nrd <= 0;
      o_nwr <= 0;
      o_lastw <= 16'h0000;
    end else if (i_req && i_we) begin
      o_nwr <= o_nwr + 1;
      o_lastw <= i_wdata;
    end else if (i_req) begin
      o_nrd <= o_nrd + 1;
    end
  end
endmodule
`default_nettype wire

// ===== bench/bcx_exec_assertions.sv
// concurrent checks on the exec block ports
`timescale 1ns/100ps
`default_nettype none
module bcx_exec_chk (
  // clock, reset and issue
  input wire logic             i_clk,
  input wire logic             i_rst_n,
  input wire logic             i_start,
  input wire bcx_pkg::bcx_op_t i_op,
  // watched outputs
  input wire logic             o_busy,
  input wire logic             o_done,
  input wire logic             o_taken,
  input wire logic             o_mem_req,
  input wire logic             o_mem_we,
  input wire logic             o_reg_xfer,
  input wire logic             o_pc_load,
  input wire logic             o_fp_load,
  input wire logic             o_flag_hold,
  input wire logic [6:0]       o_cond_code
);
  import bcx_pkg::*;
  logic go;
  // an issue counts only while idle
  assign go = i_start && !o_busy;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  busy_done_pair_a: assert property (o_done == $fell(o_busy))
    else $error("done not at busy end");
  taken_at_done_a: assert property (o_taken |-> o_done)
    else $error("taken without done");
  xfer_with_access_a: assert property (o_reg_xfer |-> o_mem_req)
    else $error("transfer without access");
  near_return_a:
    assert property (go && i_op == OP_RET |=> o_mem_req ##1 (!o_mem_req)[*3] ##1 o_pc_load)
    else $error("near return timing");
  frame_setup_a:
    assert property (go && i_op == OP_LINK |=> o_mem_req && o_mem_we ##6 o_fp_load)
    else $error("frame setup timing");
  soft_int_flags_a:
    assert property (go && i_op == OP_INT_A16 && !o_flag_hold |-> ##17 o_cond_code[6:5] == 2'b01)
    else $error("soft interrupt flags");
  ctx_switch_a:
    assert property (go && i_op == OP_CTX_SWITCH |=> o_mem_req[*6] ##9 o_done)
    else $error("context switch timing");
  int_return_a:
    assert property (go && i_op == OP_INT_RETURN |=> (o_mem_req && !o_mem_we)[*6] ##10 o_done)
    else $error("interrupt return timing");
endmodule
bind bcx_exec bcx_exec_chk chk_u (.i_clk, .i_rst_n, .i_start, .i_op, .o_busy, .o_done,
  .o_taken, .o_mem_req, .o_mem_we, .o_reg_xfer, .o_pc_load, .o_fp_load, .o_flag_hold,
  .o_cond_code);
`default_nettype wire

// ===== bench/bcx_exec_tb_top.sv
// self-checking bench for the exec block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("MISMATCH t=%0t %s", $time, m); \
  end \
end
module bcx_exec_tb_top;
  import bcx_pkg::*;
  // design ports
  logic        i_clk, i_rst_n, i_start, i_word, i_reg_wr, i_reg_rd;
  bcx_op_t     i_op;
  bcx_bank_t   i_bank;
  logic [15:0] i_opnd, i_imm, i_reg_wdata, i_mem_rdata, o_mem_wdata, o_result, o_pc, o_fp;
  logic [15:0] o_reg_rdata;
  logic [7:0]  i_rlst, i_bank_val, i_reg_addr, o_prog_bank, o_reg_bank_ptr;
  logic [3:0]  i_ea_cost;
  logic        o_mem_req, o_mem_we, o_reg_xfer, o_busy, o_done, o_taken, o_wb, o_acc_load;
  logic        o_pc_load, o_fp_load, o_space_ovr, o_flag_hold, o_shared_bank;
  logic [6:0]  o_cond_code, prev;
  logic [2:0]  o_int_level_mask;
  logic [1:0]  o_space;
  // stimulus and expectations
  bcx_op_t     op;
  bcx_bank_t   bk;
  logic [15:0] a, b, base, lastw;
  logic [7:0]  rl, bv;
  logic [3:0]  cost;
  logic        w;
  int          err_total, n_tests, nrd, nwr, r0, n, ec, ea;

  bcx_exec dut_u (.*);
  bcx_mem_model mem_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_wdata(o_mem_wdata), .i_base(base), .o_rdata(i_mem_rdata), .o_nrd(nrd), .o_nwr(nwr),
    .o_lastw(lastw));

  // random operands; memory forms take any cost from 0 to 15
  function automatic void pick();
    {a, b} = $urandom;
    base = 16'($urandom);
    {w, cost, rl, bv} = 21'($urandom);
    bk = bcx_bank_t'(3'($urandom % 7));
  endfunction
  // branch decision: nonzero difference or decremented value
  function automatic logic tk(bcx_op_t o);
    logic [15:0] v, c;
    v = (o == OP_CMP_MEM || o == OP_DEC_MEM) ? base : a;
    c = (o >= OP_DEC_REG) ? 16'h0000 : b;
    if (o >= OP_DEC_REG) v = v - 16'h0001;
    return w ? (v != c) : (v[7:0] != c[7:0]);
  endfunction
  // expected cycles in ec and word accesses in ea
  function automatic void calc(bcx_op_t o);
    int c = 0, lo = 0, hi = 0, t;
    t = int'(tk(o));
    for (int k = 7; k >= 0; k--) if (rl[k]) lo = k;
    for (int k = 0; k < 8; k++) if (rl[k]) {hi, c} = {k, c + 1};
    case (o)
      OP_CMP_ACC: ec = 4 + t;
      OP_CMP_REG: ec = (w ? 7 : 12) + t;
      OP_CMP_MEM: ec = 6 + int'(cost) + t;
      OP_DEC_REG: ec = 6 + t;
      OP_DEC_MEM: ec = 7 + int'(cost) + t;
      OP_INT_VEC, OP_INT_ONE: ec = 20;
      OP_INT_A16: ec = 16;
      OP_INT_FAR: ec = 17;
      OP_INT_RETURN: ec = 15;
      OP_LINK, OP_FAR_RETURN: ec = 6;
      OP_FRAME_TEARDOWN: ec = 5;
      OP_RET: ec = 4;
      OP_PUSH_LIST: ec = c != 0 ? 29 + c - 3 * lo : 8;
      OP_POP_LIST: ec = c != 0 ? 7 + 3 * c + 2 * hi : 7;
      OP_CTX_SWITCH: ec = 14;
      OP_AND_COND, OP_OR_COND: ec = 3;
      OP_MOV_RBP, OP_MOV_ILM: ec = 2;
      OP_RD_BANK: ec = (bk >= BANK_DATA) ? 2 : 1;
      default: ec = 1;
    endcase
    case (o)
      OP_INT_VEC, OP_INT_ONE: ea = 8;
      OP_INT_A16, OP_INT_FAR, OP_INT_RETURN, OP_CTX_SWITCH: ea = 6;
      OP_FAR_RETURN, OP_DEC_MEM: ea = 2;
      OP_LINK, OP_FRAME_TEARDOWN, OP_RET, OP_CMP_MEM: ea = 1;
      OP_PUSH_LIST, OP_POP_LIST: ea = c;
      default: ea = 0;
    endcase
  endfunction
  // issue one instruction, count cycles to done
  task automatic run(bcx_op_t o);
    @(posedge i_clk);
    i_op <= o;
    i_word <= w;
    i_opnd <= a;
    i_imm <= b;
    i_ea_cost <= cost;
    i_rlst <= rl;
    i_bank <= bk;
    i_bank_val <= bv;
    i_start <= 1'b1;
    r0 = nrd + nwr;
    @(posedge i_clk);
    i_start <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
      #1;
    end while (o_done !== 1'b1 && n < 99);
    if (n >= 99) begin
      err_total++;
      summarize();
    end
    calc(o);
  endtask
  // register port: one-cycle strobes, read data a cycle later
  task automatic rw(logic [7:0] ad, logic [15:0] d, logic rd);
    @(posedge i_clk);
    i_reg_addr <= ad;
    i_reg_wdata <= d;
    i_reg_wr <= !rd;
    i_reg_rd <= rd;
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd} <= 2'b00;
    if (rd) #1 `CHK(o_reg_rdata, d, "register read")
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // free-running 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // main sequence
  initial begin
    {i_rst_n, i_start, i_word, i_reg_wr, i_reg_rd} = 5'h00;
    i_op = OP_NOP;
    i_bank = BANK_PROG;
    {i_opnd, i_imm, i_reg_wdata} = 48'h0;
    {i_ea_cost, i_rlst, i_bank_val, i_reg_addr} = 28'h0;
    void'($urandom(94921));
    pick();
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rw(8'h00, 16'h0000, 1'b1);
    rw(8'h08, 16'h0000, 1'b1);
    rw(8'h04, b, 1'b0);
    rw(8'h04, {8'h00, b[7:0]}, 1'b1);
    rw(8'h40, 16'h0000, 1'b1);
    // branches, with equal and count-to-zero corners
    for (int i = 0; i < 60; i++) begin
      pick();
      op = bcx_op_t'(5'(1 + i % 5));
      if (i % 4 == 0) {b, base} = {a, a};
      if (i % 4 == 1) {a, base} = 32'h0001_0001;
      run(op);
      `CHK(n, ec, "branch cycles")
      `CHK(o_taken, tk(op), "branch decision")
      `CHK(nrd + nwr - r0, ea, "branch accesses")
      if (op == OP_CMP_REG) `CHK(o_cond_code[2], !tk(op), "compare zero flag")
      if (w && op == OP_DEC_REG) `CHK({o_wb, o_result}, {1'b1, a - 16'h0001}, "dec")
      if (w && op == OP_DEC_MEM) `CHK(lastw, base - 16'h0001, "dec write")
    end
    // other classes, empty register list first
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 29; k++) begin
        if (k >= 1 && k <= 5) continue;
        op = bcx_op_t'(5'(k));
        pick();
        if (p == 0) rl = 8'h00;
        prev = o_cond_code;
        run(op);
        `CHK(n, ec, "op cycles")
        `CHK(nrd + nwr - r0, ea, "op accesses")
        case (op)
          OP_NOP: `CHK(o_cond_code, prev, "idle flags")
          OP_INT_VEC, OP_INT_A16, OP_INT_FAR, OP_INT_ONE:
            `CHK(o_cond_code[6:5], 2'b01, "interrupt flags")
          OP_INT_RETURN, OP_CTX_SWITCH:
            `CHK({o_cond_code, o_pc}, {base[6:0], base}, "restore")
          OP_LINK: `CHK({o_fp, lastw}, {b, a}, "frame setup")
          OP_FRAME_TEARDOWN: `CHK(o_fp, base, "frame teardown")
          OP_RET: `CHK(o_pc, base, "near return")
          OP_FAR_RETURN: `CHK({o_prog_bank, o_pc}, {base[7:0], base}, "far return")
          OP_AND_COND: `CHK(o_cond_code, prev & b[6:0], "flag and")
          OP_OR_COND: `CHK(o_cond_code, prev | b[6:0], "flag or")
          OP_MOV_RBP: `CHK(o_reg_bank_ptr, b[7:0], "bank pointer")
          OP_MOV_ILM: `CHK(o_int_level_mask, b[2:0], "level mask")
          OP_RD_BANK: `CHK({o_acc_load, o_result}, {9'h100, bv}, "bank read")
          OP_PFX_ADD, OP_PFX_DATA, OP_PFX_PROG, OP_PFX_STACK:
            `CHK({o_space_ovr, o_space}, {1'b1, 2'(k - 23)}, "space prefix")
          OP_PFX_NOFLAG: `CHK(o_flag_hold, 1'b1, "flag hold")
          OP_PFX_SHARED: `CHK(o_shared_bank, 1'b1, "shared bank")
          default: ;
        endcase
      end
      // no-flag prefix holds the next update
      b = 16'h007f;
      prev = o_cond_code;
      run(OP_OR_COND);
      `CHK(o_cond_code, prev, "flags held")
    end
    summarize();
  end
endmodule
`default_nettype wire
